// file: core/cats_pkg.sv
// Notes on behaviour
// - Any accepted arm setting change marks acquired measurement data invalid.
// - Start sequence leaves idle on immediate initiate or continuous enable.
// - Start arm layer passes straight on when source immediate, else waits arm event.
// - Start trigger state waits comparator condition, then begins measurement.
// - After begin, start sequence holds in ST_HOLD until end of measurement.
// - Begin moves stop sequence to arm; immediate source passes, else waits event.
// - Stop trigger state waits comparator condition, then signals end of measurement.
// - On end, incomplete count re-arms; complete count climbs to initiated layer.
// - Initiated layer re-arms when continuous is on, otherwise returns to idle.
// - Immediate initiate runs one cycle from idle; outside idle ignored, error -213.
// - Idle holds until initiate or continuous on; continuous chains cycles; resets off.
// - Continuous off during operation finishes the current cycle before idle.
// - Continuous on outside idle has no effect and queues error -213; off is taken in any state.
// - Abort forces idle at once and keeps all configuration.
// - Start slope positive, negative or default; resets positive; outside idle -221.
// - Stop slope positive, negative or default; outside idle ignored, error -221.
// - Sources are immediate, external arm or trigger line 0..7; reset immediate.
// - Start source selection coerces stop source so ext and line never mix.
// - Stop source selection coerces start source likewise.
// - A trigger line owned by a gate output is rejected with error -221.
// - Source change outside idle ignored; start queues -221, stop queues -213.
// - Full error queue overwrites its newest entry with -350; the new error is dropped.
package cats_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_CMD     = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CONT    = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STA_SRC = 8'h08;
   localparam logic [ADDR_W-1:0] REG_STA_SLP = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_STP_SRC = 8'h10;
   localparam logic [ADDR_W-1:0] REG_STP_SLP = 8'h14;
   localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h18;
   localparam logic [ADDR_W-1:0] REG_ERRQ    = 8'h1C;
   localparam logic [ADDR_W-1:0] REG_MCOUNT  = 8'h20;
   // Field positions
   localparam int CMD_INIT_BIT  = 0;
   localparam int CMD_ABORT_BIT = 1;
   localparam int CONT_BIT      = 0;
   localparam int STS_START_LSB = 0;
   localparam int STS_STOP_LSB  = 4;
   localparam int STS_CONT_BIT  = 8;
   localparam int STS_DV_BIT    = 9;
   localparam int STS_EQ_LSB    = 12;
   // Arm source: 0 immediate, 1 external arm, 8..F trigger line 0..7
   localparam int SRC_W = 4;
   localparam int LINE_W = 3;
   localparam int NLINES = 8;
   localparam int SRC_TRIG_BIT = 3;
   localparam logic [SRC_W-1:0] SRC_IMM = 4'h0;
   localparam logic [SRC_W-1:0] SRC_EXT = 4'h1;
   localparam int SLP_W = 2;
   localparam logic [SLP_W-1:0] SLP_POS = 2'h0;
   localparam logic [SLP_W-1:0] SLP_NEG = 2'h1;
   localparam logic [SLP_W-1:0] SLP_DEF = 2'h2;
   // Error codes, 16-bit two's complement
   localparam int ERR_W = 16;
   localparam logic [ERR_W-1:0] ERR_NONE     = 16'h0000;
   localparam logic [ERR_W-1:0] ERR_INIT_IGN = 16'hFF2B;
   localparam logic [ERR_W-1:0] ERR_CONFLICT = 16'hFF23;
   localparam logic [ERR_W-1:0] ERR_OVERFLOW = 16'hFEA2;
   localparam int EQ_PTR_W = 2;
   localparam int EQ_CNT_W = 3;
   localparam logic [EQ_CNT_W-1:0] EQ_DEPTH = 3'h4;
   localparam int MCNT_W = 8;
   localparam logic [MCNT_W-1:0] MCNT_RESET = 8'h01;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_INIT = 3'h1,
      ST_ARM  = 3'h3,
      ST_TRIG = 3'h2,
      ST_HOLD = 3'h6
   } cats_start_t;

   typedef enum logic [1:0] {
      SP_IDLE = 2'h0,
      SP_ARM  = 2'h1,
      SP_TRIG = 2'h3
   } cats_stop_t;
endpackage

// file: core/cats_seq.sv
`timescale 1ns/10ps
module cats_seq
   import cats_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk_in,
   input  wire logic              srst_in,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   // Arm and trigger inputs
   input  wire logic              ext_arm_in,
   input  wire logic [NLINES-1:0] trig_line_in,
   input  wire logic [NLINES-1:0] gate_owned_in,
   input  wire logic              start_cond_in,
   input  wire logic              stop_cond_in,
   // Measurement actions and state
   output logic                   begin_meas_out,
   output logic                   end_meas_out,
   output logic                   idle_out,
   output logic                   data_valid_out
);

   cats_start_t       start_q;
   cats_stop_t        stop_q;
   logic              fresh_q;
   logic              cont_q;
   logic              begin_q;
   logic              end_q;
   logic              data_valid_q;
   logic [SRC_W-1:0]  start_src_q;
   logic [SRC_W-1:0]  stop_src_q;
   logic [SLP_W-1:0]  start_slp_q;
   logic [SLP_W-1:0]  stop_slp_q;
   logic [MCNT_W-1:0] mcount_q;
   logic [MCNT_W-1:0] meas_cnt_q;
   logic              ext_prev_q;
   logic [NLINES-1:0] line_prev_q;
   logic [ERR_W-1:0]  eq_mem [EQ_DEPTH];
   logic [EQ_PTR_W-1:0] eq_wr_q;
   logic [EQ_PTR_W-1:0] eq_rd_q;
   logic [EQ_CNT_W-1:0] eq_cnt_q;
   logic [DATA_W-1:0] rdata_q;

   logic              is_idle;
   logic              wr_cmd;
   logic              wr_cont;
   logic              wr_sta_src;
   logic              wr_stp_src;
   logic              wr_sta_slp;
   logic              wr_stp_slp;
   logic              init_req;
   logic              abort_req;
   logic              cont_on_req;
   logic              cont_off_req;
   logic [SRC_W-1:0]  new_src;
   logic [SLP_W-1:0]  new_slp;
   logic              src_good;
   logic              slp_good;
   logic              sta_src_ok;
   logic              stp_src_ok;
   logic              sta_slp_ok;
   logic              stp_slp_ok;
   logic              arm_chg;
   logic              err_push;
   logic [ERR_W-1:0]  err_code;
   logic              eq_pop;
   logic              eq_full;
   logic              start_hit;
   logic              stop_hit;
   logic              count_done;
   logic [MCNT_W-1:0] mcount_eff;
   logic [DATA_W-1:0] status_w;

   // Legal encoding and not a line already driven by a gate output
   function automatic logic src_legal(input logic [SRC_W-1:0] s,
                                      input logic [NLINES-1:0] owned);
      if (s[SRC_TRIG_BIT])
         return !owned[s[LINE_W-1:0]];
      return (s == SRC_IMM) || (s == SRC_EXT);
   endfunction

   // Keeps external arm and trigger lines from mixing across the two sources
   function automatic logic [SRC_W-1:0] coerce(input logic [SRC_W-1:0] sel,
                                               input logic [SRC_W-1:0] other);
      if ((sel == SRC_EXT) && other[SRC_TRIG_BIT])
         return SRC_EXT;
      if (sel[SRC_TRIG_BIT] && (other == SRC_EXT))
         return sel;
      return other;
   endfunction

   // Arm event: immediate always passes, else the chosen edge of the source
   function automatic logic arm_hit(input logic [SRC_W-1:0] s,
                                    input logic [SLP_W-1:0] slp,
                                    input logic ext, input logic ext_p,
                                    input logic [NLINES-1:0] ln,
                                    input logic [NLINES-1:0] ln_p);
      logic c;
      logic p;
      c = s[SRC_TRIG_BIT] ? ln[s[LINE_W-1:0]] : ext;
      p = s[SRC_TRIG_BIT] ? ln_p[s[LINE_W-1:0]] : ext_p;
      if (s == SRC_IMM)
         return 1'b1;
      if (slp == SLP_NEG)
         return !c && p;
      return c && !p;
   endfunction

   assign is_idle      = (start_q == ST_IDLE);
   assign wr_cmd       = reg_wr_in && (reg_addr_in == REG_CMD);
   assign wr_cont      = reg_wr_in && (reg_addr_in == REG_CONT);
   assign wr_sta_src   = reg_wr_in && (reg_addr_in == REG_STA_SRC);
   assign wr_stp_src   = reg_wr_in && (reg_addr_in == REG_STP_SRC);
   assign wr_sta_slp   = reg_wr_in && (reg_addr_in == REG_STA_SLP);
   assign wr_stp_slp   = reg_wr_in && (reg_addr_in == REG_STP_SLP);
   // Abort outranks an initiate written in the same word
   assign abort_req    = wr_cmd && reg_wdata_in[CMD_ABORT_BIT];
   assign init_req     = wr_cmd && reg_wdata_in[CMD_INIT_BIT] && !abort_req;
   assign cont_on_req  = wr_cont && reg_wdata_in[CONT_BIT];
   assign cont_off_req = wr_cont && !reg_wdata_in[CONT_BIT];
   assign new_src      = reg_wdata_in[SRC_W-1:0];
   assign new_slp      = reg_wdata_in[SLP_W-1:0];
   assign src_good     = src_legal(new_src, gate_owned_in);
   assign slp_good     = (new_slp == SLP_POS) || (new_slp == SLP_NEG) || (new_slp == SLP_DEF);
   assign sta_src_ok   = wr_sta_src && is_idle && src_good;
   assign stp_src_ok   = wr_stp_src && is_idle && src_good;
   assign sta_slp_ok   = wr_sta_slp && is_idle && slp_good;
   assign stp_slp_ok   = wr_stp_slp && is_idle && slp_good;
   assign arm_chg      = sta_src_ok || stp_src_ok || sta_slp_ok || stp_slp_ok;

   // Error source; only one register write per cycle, so one code at most
   always_comb
   begin
      err_push = 1'b0;
      err_code = ERR_NONE;
      if (init_req && !is_idle)
      begin
         err_push = 1'b1;
         err_code = ERR_INIT_IGN;
      end
      if (cont_on_req && !is_idle)
      begin
         err_push = 1'b1;
         err_code = ERR_INIT_IGN;
      end
      if (wr_sta_src && !sta_src_ok)
      begin
         err_push = 1'b1;
         err_code = ERR_CONFLICT;
      end
      if (wr_stp_src && !stp_src_ok)
      begin
         err_push = 1'b1;
         err_code = is_idle ? ERR_CONFLICT : ERR_INIT_IGN;
      end
      if ((wr_sta_slp && !sta_slp_ok) || (wr_stp_slp && !stp_slp_ok))
      begin
         err_push = 1'b1;
         err_code = ERR_CONFLICT;
      end
   end

   assign start_hit  = arm_hit(start_src_q, start_slp_q, ext_arm_in, ext_prev_q,
                               trig_line_in, line_prev_q);
   assign stop_hit   = arm_hit(stop_src_q, stop_slp_q, ext_arm_in, ext_prev_q,
                               trig_line_in, line_prev_q);
   assign mcount_eff = (mcount_q == '0) ? MCNT_RESET : mcount_q;
   assign count_done = (meas_cnt_q + MCNT_RESET) >= mcount_eff;

   // Follows the pins through reset as well, so release brings no false edge
   always_ff @(posedge mclk_in)
   begin
      ext_prev_q  <= ext_arm_in;
      line_prev_q <= trig_line_in;
   end

   // Start sequence
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         start_q <= ST_IDLE;
      else if (abort_req)
         start_q <= ST_IDLE;
      else
         unique case (start_q)
            ST_IDLE:
               if (init_req || cont_on_req)
                  start_q <= ST_INIT;
            ST_INIT:
               start_q <= (fresh_q || cont_q) ? ST_ARM : ST_IDLE;
            ST_ARM:
               if (start_hit)
                  start_q <= ST_TRIG;
            ST_TRIG:
               if (start_cond_in)
                  start_q <= ST_HOLD;
            // Held until end, then count check
            ST_HOLD:
               if (end_q)
                  start_q <= count_done ? ST_INIT : ST_ARM;
         endcase
   end

   // First pass through the initiated layer always goes down to arm
   always_ff @(posedge mclk_in)
   begin
      if (srst_in || abort_req || (start_q == ST_INIT))
         fresh_q <= 1'b0;
      else if (is_idle && (init_req || cont_on_req))
         fresh_q <= 1'b1;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in || (start_q == ST_INIT))
         meas_cnt_q <= '0;
      else if ((start_q == ST_HOLD) && end_q)
         meas_cnt_q <= meas_cnt_q + MCNT_RESET;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         begin_q <= 1'b0;
      else
         begin_q <= (start_q == ST_TRIG) && start_cond_in && !abort_req;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in || abort_req)
         stop_q <= SP_IDLE;
      else
         unique case (stop_q)
            SP_IDLE:
               if (begin_q)
                  stop_q <= SP_ARM;
            SP_ARM:
               if (stop_hit)
                  stop_q <= SP_TRIG;
            SP_TRIG:
               if (stop_cond_in)
                  stop_q <= SP_IDLE;
         endcase
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         end_q <= 1'b0;
      else
         end_q <= (stop_q == SP_TRIG) && stop_cond_in && !abort_req;
   end

   // Continuous mode; off is taken in any state
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         cont_q <= 1'b0;
      else if (cont_off_req)
         cont_q <= 1'b0;
      else if (cont_on_req && is_idle)
         cont_q <= 1'b1;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         start_src_q <= SRC_IMM;
         stop_src_q  <= SRC_IMM;
      end
      else if (sta_src_ok)
      begin
         start_src_q <= new_src;
         stop_src_q  <= coerce(new_src, stop_src_q);
      end
      else if (stp_src_ok)
      begin
         stop_src_q  <= new_src;
         start_src_q <= coerce(new_src, start_src_q);
      end
   end

   // Slopes; default is stored as positive
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         start_slp_q <= SLP_POS;
         stop_slp_q  <= SLP_POS;
      end
      else if (sta_slp_ok)
         start_slp_q <= (new_slp == SLP_NEG) ? SLP_NEG : SLP_POS;
      else if (stp_slp_ok)
         stop_slp_q  <= (new_slp == SLP_NEG) ? SLP_NEG : SLP_POS;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         mcount_q <= MCNT_RESET;
      else if (reg_wr_in && (reg_addr_in == REG_MCOUNT))
         mcount_q <= reg_wdata_in[MCNT_W-1:0];
   end

   // Completed measurement is valid until an arm setting changes
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         data_valid_q <= 1'b0;
      else if (end_q)
         data_valid_q <= 1'b1;
      else if (arm_chg)
         data_valid_q <= 1'b0;
   end

   // Error queue; a read of the queue register pops the oldest code
   assign eq_pop  = reg_rd_in && (reg_addr_in == REG_ERRQ) && (eq_cnt_q != '0);
   assign eq_full = (eq_cnt_q == EQ_DEPTH) && !eq_pop;

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         eq_wr_q  <= '0;
         eq_rd_q  <= '0;
         eq_cnt_q <= '0;
      end
      else
      begin
         if (eq_pop)
            eq_rd_q <= eq_rd_q + 2'h1;
         if (err_push && !eq_full)
            eq_wr_q <= eq_wr_q + 2'h1;
         if ((err_push && !eq_full) && !eq_pop)
            eq_cnt_q <= eq_cnt_q + 3'h1;
         else if (eq_pop && !(err_push && !eq_full))
            eq_cnt_q <= eq_cnt_q - 3'h1;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (err_push && eq_full)
         eq_mem[eq_wr_q - 2'h1] <= ERR_OVERFLOW;
      else if (err_push)
         eq_mem[eq_wr_q] <= err_code;
   end

   always_comb
   begin
      status_w = '0;
      status_w[STS_START_LSB +: 3] = start_q;
      status_w[STS_STOP_LSB +: 2] = stop_q;
      status_w[STS_CONT_BIT] = cont_q;
      status_w[STS_DV_BIT] = data_valid_q;
      status_w[STS_EQ_LSB +: EQ_CNT_W] = eq_cnt_q;
   end

   // Read data stand one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge mclk_in)
   begin
      if (srst_in || !reg_rd_in)
         rdata_q <= '0;
      else
         unique case (reg_addr_in)
            REG_CONT:    rdata_q <= DATA_W'(cont_q);
            REG_STA_SRC: rdata_q <= DATA_W'(start_src_q);
            REG_STP_SRC: rdata_q <= DATA_W'(stop_src_q);
            REG_STA_SLP: rdata_q <= DATA_W'(start_slp_q);
            REG_STP_SLP: rdata_q <= DATA_W'(stop_slp_q);
            REG_STATUS:  rdata_q <= status_w;
            REG_ERRQ:    rdata_q <= eq_pop ? DATA_W'(eq_mem[eq_rd_q]) : '0;
            REG_MCOUNT:  rdata_q <= DATA_W'(mcount_q);
            default:     rdata_q <= '0;
         endcase
   end

   assign reg_rdata_out  = rdata_q;
   assign begin_meas_out = begin_q;
   assign end_meas_out   = end_q;
   assign idle_out       = is_idle;
   assign data_valid_out = data_valid_q;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);

   chk_dv_invalid: assert property (arm_chg && !end_q |=> !data_valid_q)
      else $error("data still valid after arm change");
   chk_launch_init: assert property (is_idle && (init_req || cont_on_req) |=> start_q == ST_INIT)
      else $error("launch did not reach initiated");
   chk_imm_arm: assert property (start_q == ST_ARM && start_src_q == SRC_IMM && !abort_req
      |=> start_q == ST_TRIG)
      else $error("immediate start arm did not pass");
   chk_begin_hold: assert property (start_q == ST_TRIG && start_cond_in && !abort_req
      |=> begin_q && start_q == ST_HOLD)
      else $error("begin not issued");
   chk_hold_wait: assert property (start_q == ST_HOLD && !end_q && !abort_req
      |=> start_q == ST_HOLD)
      else $error("start left hold early");
   chk_stop_follow: assert property (begin_q && !abort_req ##1 !abort_req
      |-> stop_q == SP_ARM)
      else $error("stop sequence not armed by begin");
   chk_end_pulse: assert property (stop_q == SP_TRIG && stop_cond_in && !abort_req
      |=> end_q ##1 !end_q)
      else $error("end pulse wrong");
   chk_count_path: assert property (start_q == ST_HOLD && end_q && !abort_req
      |=> start_q == ($past(count_done) ? ST_INIT : ST_ARM))
      else $error("wrong path after end");
   chk_single_idle: assert property (start_q == ST_INIT && !fresh_q && !cont_q && !abort_req
      |=> is_idle)
      else $error("single cycle did not return idle");
   chk_init_refused: assert property (init_req && !is_idle && !abort_req
      |=> start_q != ST_IDLE || $past(start_q) == ST_INIT || $past(end_q))
      else $error("refused initiate disturbed sequence");
   chk_cont_reject: assert property (cont_on_req && !is_idle |=> cont_q == $past(cont_q))
      else $error("continuous changed outside idle");
   chk_abort_idle: assert property (abort_req |=> is_idle && stop_q == SP_IDLE
      && start_src_q == $past(start_src_q) && cont_q == $past(cont_q))
      else $error("abort did not idle or lost config");
   chk_no_mix: assert property (!((start_src_q == SRC_EXT) && stop_src_q[SRC_TRIG_BIT])
      && !((stop_src_q == SRC_EXT) && start_src_q[SRC_TRIG_BIT]))
      else $error("ext arm mixed with trigger line");
   chk_owned_line: assert property (wr_sta_src && new_src[SRC_TRIG_BIT]
      && gate_owned_in[new_src[LINE_W-1:0]] |=> $stable(start_src_q))
      else $error("owned line accepted");
   chk_queue_ovf: assert property (err_push && eq_full
      |=> eq_cnt_q == EQ_DEPTH && eq_mem[eq_wr_q - 2'h1] == ERR_OVERFLOW)
      else $error("overflow code not recorded");

   cov_single_run: cover property (start_q == ST_HOLD && end_q && !cont_q ##2 is_idle);
   cov_cont_chain: cover property (start_q == ST_INIT && cont_q && !fresh_q ##1 start_q == ST_ARM);
   cov_abort_run: cover property (abort_req && start_q == ST_HOLD);
   cov_overflow: cover property (err_push && eq_full);

endmodule

// file: verif/cats_far.sv
`timescale 1ns/10ps
module cats_far
   import cats_pkg::*;
(
   // Clock, reset and pace
   input  wire logic              mclk_in,
   input  wire logic              srst_in,
   input  wire logic              slow_in,
   // Comparator and backplane stand-ins
   output logic                   start_cond_out,
   output logic                   stop_cond_out,
   output logic                   ext_arm_out,
   output logic      [NLINES-1:0] trig_line_out
);
   logic [3:0] pace_q;

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         pace_q <= 4'h0;
      else
         pace_q <= pace_q + 4'h1;
   end

   // Slow pace keeps conditions rare so commands land outside idle
   assign start_cond_out = !slow_in || (pace_q == 4'h3);
   assign stop_cond_out  = !slow_in || (pace_q == 4'hB);
   // Lines keep toggling so every arm source sees edges
   assign ext_arm_out    = pace_q[2];
   assign trig_line_out  = {NLINES{pace_q[3]}} ^ 8'h55;
endmodule

// file: verif/test_counter_arm_trigger_sequencer.sv
`timescale 1ns/10ps
module test_counter_arm_trigger_sequencer;
   import cats_pkg::*;
   logic              mclk_in = 1'b0;
   logic              srst_in = 1'b1;
   logic [ADDR_W-1:0] addr    = 8'h00;
   logic [DATA_W-1:0] wdata   = 32'h0;
   logic              wr      = 1'b0;
   logic              rd      = 1'b0;
   logic              rd_q    = 1'b0;
   logic              slow    = 1'b1;
   logic [NLINES-1:0] owned   = 8'h00;
   logic [DATA_W-1:0] rdata;
   logic [NLINES-1:0] lines;
   logic              ext, scond, pcond, bgn, fin, idle, dvalid;
   logic [DATA_W-1:0] exp_q[$];
   int                err_total = 0;
   int                n_tests = 0;
   int                n_begin = 0;
   int                n_end   = 0;
   int                cyc = 0;
   int                n;

   cats_seq DUT (.mclk_in(mclk_in), .srst_in(srst_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .ext_arm_in(ext), .trig_line_in(lines), .gate_owned_in(owned),
      .start_cond_in(scond), .stop_cond_in(pcond), .begin_meas_out(bgn),
      .end_meas_out(fin), .idle_out(idle), .data_valid_out(dvalid));
   cats_far far (.mclk_in(mclk_in), .srst_in(srst_in), .slow_in(slow),
      .start_cond_out(scond), .stop_cond_out(pcond), .ext_arm_out(ext),
      .trig_line_out(lines));

   initial
   begin
      forever #20 mclk_in = ~mclk_in;
   end

   task automatic stop_test();
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   // Each strobe is followed by one quiet cycle
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic run_wait();
      int k;
      k = 0;
      while (idle !== 1'b1 && k < 400)
      begin
         @(posedge mclk_in);
         k++;
      end
      chk(idle === 1'b1, "sequencer never returned to idle");
   endtask

   // Read data is checked in the cycle after its strobe only
   always @(posedge mclk_in)
   begin
      rd_q <= rd;
      cyc <= cyc + 1;
      if (bgn === 1'b1)
         n_begin <= n_begin + 1;
      if (fin === 1'b1)
         n_end <= n_end + 1;
      if (rd_q === 1'b1)
      begin
         n_tests++;
         if (exp_q.size() == 0 || rdata !== exp_q[0])
         begin
            err_total++;
            $display("unexpected at %0t: read %h", $time, rdata);
         end
         void'(exp_q.pop_front());
      end
      if (cyc == 20000)
      begin
         err_total++;
         $display("unexpected at %0t: run timed out", $time);
         stop_test();
      end
   end

   initial
   begin
      void'($urandom(95));
      repeat (2) @(posedge mclk_in);
      srst_in <= 1'b0;
      @(posedge mclk_in);
      rd_reg(REG_STA_SRC, 32'h0);
      rd_reg(REG_STP_SRC, 32'h0);
      rd_reg(REG_STA_SLP, {30'h0, SLP_POS});
      rd_reg(REG_CONT, 32'h0);
      $display("reset values done");
      n = $urandom_range(3, 1);
      wr_reg(REG_MCOUNT, n);
      n_begin = 0;
      n_end = 0;
      wr_reg(REG_CMD, 32'h1);
      wr_reg(REG_CMD, 32'h1);
      wr_reg(REG_STA_SLP, 32'h1);
      wr_reg(REG_CONT, 32'h1);
      run_wait();
      chk(n_begin == n, "begin count differs from measurement count");
      chk(n_end == n, "end count differs from measurement count");
      chk(dvalid === 1'b1, "data not valid after run");
      rd_reg(REG_ERRQ, {16'h0, ERR_INIT_IGN});
      rd_reg(REG_ERRQ, {16'h0, ERR_CONFLICT});
      rd_reg(REG_ERRQ, {16'h0, ERR_INIT_IGN});
      rd_reg(REG_STA_SLP, 32'h0);
      rd_reg(REG_STATUS, 32'h200);
      wr_reg(REG_STA_SLP, 32'h1);
      chk(dvalid === 1'b0, "data still valid after arm change");
      rd_reg(REG_STA_SLP, 32'h1);
      wr_reg(REG_STP_SLP, 32'h2);
      rd_reg(REG_STP_SLP, 32'h0);
      rd_reg(REG_STATUS, 32'h0);
      $display("single cycle done");
      wr_reg(REG_STP_SRC, 32'hA);
      wr_reg(REG_STA_SRC, 32'h1);
      rd_reg(REG_STP_SRC, 32'h1);
      wr_reg(REG_STP_SRC, 32'hB);
      rd_reg(REG_STA_SRC, 32'hB);
      owned <= 8'h20;
      wr_reg(REG_STA_SRC, 32'hD);
      rd_reg(REG_STA_SRC, 32'hB);
      rd_reg(REG_ERRQ, {16'h0, ERR_CONFLICT});
      repeat (5) wr_reg(REG_STA_SLP, 32'h3);
      rd_reg(REG_STATUS, 32'h4000);
      repeat (3) rd_reg(REG_ERRQ, {16'h0, ERR_CONFLICT});
      rd_reg(REG_ERRQ, {16'h0, ERR_OVERFLOW});
      n_begin = 0;
      wr_reg(REG_CMD, 32'h1);
      run_wait();
      chk(n_begin == n, "line armed run count differs");
      wr_reg(REG_STA_SRC, 32'h0);
      wr_reg(REG_STP_SRC, 32'h0);
      $display("arm sources done");
      slow <= 1'b0;
      n_begin = 0;
      n_end = 0;
      wr_reg(REG_CONT, 32'h1);
      repeat (40) @(posedge mclk_in);
      chk(idle === 1'b0, "continuous mode went idle");
      wr_reg(REG_CONT, 32'h0);
      run_wait();
      chk(n_end > 0 && n_begin == n_end && n_end % n == 0, "cycle cut short");
      slow <= 1'b1;
      wr_reg(REG_CONT, 32'h1);
      repeat (3) @(posedge mclk_in);
      wr_reg(REG_STP_SRC, 32'h1);
      wr_reg(REG_STA_SRC, 32'h1);
      wr_reg(REG_CMD, 32'h2);
      chk(idle === 1'b1, "abort did not idle");
      repeat (20) @(posedge mclk_in);
      chk(idle === 1'b1 && bgn === 1'b0, "restart after abort");
      rd_reg(REG_CONT, 32'h1);
      rd_reg(REG_ERRQ, {16'h0, ERR_INIT_IGN});
      rd_reg(REG_ERRQ, {16'h0, ERR_CONFLICT});
      rd_reg(REG_STP_SRC, 32'h0);
      rd_reg(REG_STA_SRC, 32'h0);
      wr_reg(REG_CONT, 32'h0);
      $display("continuous and abort done");
      stop_test();
   end
endmodule
